/* hdl/pmrv_phy_mii_register_view.sv */
/*
 * Management register view of the two physical-layer ports, as an APB
 * slave. All control bits live here once; all but port 1's negotiation
 * enable and restart drive the port logic as flip-flop outputs; status
 * inputs are registered before being shown.
 * Assumes PHY status inputs synchronous to clock and a standard APB master.
 */
`timescale 1ns/1ps
`default_nettype none

module pmrv_phy_mii_register_view (
   input  wire logic        clock,
   input  wire logic        rst,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // Port 1 physical-layer status
   input  wire logic        p1LinkUpIn,
   input  wire logic        p1FarFaultRawIn,
   input  wire logic        p1PartnerPauseIn,
   input  wire logic [3:0]  p1PartnerAbilIn,
   // Port 1 control
   output logic             p1FarLoop,
   output logic             p1Speed100,
   output logic             p1FullDuplex,
   output logic             p1XoverStyle,
   output logic             p1AutoXoverOff,
   output logic             p1ForceXover,
   output logic             p1FarFaultDetEn,
   output logic             p1PowerDown,
   output logic             p1TxDisable,
   output logic             p1LedDisable,
   output logic             p1AdvPause,
   output logic      [3:0]  p1AdvAbil,
   // Port 2 control
   output logic             p2FarLoop,
   output logic             p2Speed100,
   output logic             p2AnEnable,
   output logic             p2PowerDown
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [31:0] rdata;
      logic        ready;
      logic        slverr;
      logic        p1FarLoop;
      logic        p1Force100;
      logic        p1AnEnable;
      logic        p1PowerDown;
      logic        p1RestartAn;
      logic        p1FullDup;
      logic        p1XoverSty;
      logic        p1ForceXov;
      logic        p1DisXover;
      logic        p1DisFef;
      logic        p1FefEn;
      logic        p1DisTx;
      logic        p1DisLed;
      logic        p1Pause;
      logic [3:0]  p1Adv;
      logic        p1Link;
      logic        p1FarFault;
      logic        p1LpPause;
      logic [3:0]  p1LpAbil;
      logic        p2FarLoop;
      logic        p2Force100;
      logic        p2AnEnable;
      logic        p2PowerDown;
   } pmrv_state_s;

   pmrv_state_s state_ff;
   pmrv_state_s nxt_state;

   logic [9:0]  wordIdx;
   logic [15:0] p1CtrlView;
   logic [15:0] p1StatView;
   logic [15:0] p1AdvView;
   logic [15:0] p1LpView;
   logic [15:0] p2CtrlView;
   logic [15:0] portCtrlView;
   logic [15:0] portStatView;
   logic [15:0] rdMux;
   logic        hit;
   logic        doWrite;

   assign wordIdx = paddr[11:2];

   // ----------------------------------------------------------------
   // Read views of the shared storage
   // ----------------------------------------------------------------
   always_comb begin
      p1CtrlView = 16'h0000; // Soft reset, isolate, collision test read 0
      p1CtrlView[pmrv_pkg::BC_FAR_LOOP]   = state_ff.p1FarLoop;
      p1CtrlView[pmrv_pkg::BC_FORCE100]   = state_ff.p1Force100;
      p1CtrlView[pmrv_pkg::BC_AN_ENABLE]  = state_ff.p1AnEnable;
      p1CtrlView[pmrv_pkg::BC_POWER_DOWN] = state_ff.p1PowerDown;
      p1CtrlView[pmrv_pkg::BC_RESTART_AN] = state_ff.p1RestartAn;
      p1CtrlView[pmrv_pkg::BC_FULL_DUP]   = state_ff.p1FullDup;
      p1CtrlView[pmrv_pkg::BC_XOVER_STY]  = state_ff.p1XoverSty;
      p1CtrlView[pmrv_pkg::BC_FORCE_XOV]  = state_ff.p1ForceXov;
      p1CtrlView[pmrv_pkg::BC_DIS_XOVER]  = state_ff.p1DisXover;
      p1CtrlView[pmrv_pkg::BC_DIS_FEF]    = state_ff.p1DisFef;
      p1CtrlView[pmrv_pkg::BC_DIS_TX]     = state_ff.p1DisTx;
      p1CtrlView[pmrv_pkg::BC_DIS_LED]    = state_ff.p1DisLed;

      p1StatView = pmrv_pkg::BS_FIXED_BITS;
      p1StatView[pmrv_pkg::BS_FAR_FAULT] = state_ff.p1FarFault;
      p1StatView[pmrv_pkg::BS_LINK_UP]   = state_ff.p1Link;

      p1AdvView = {11'h000, pmrv_pkg::AD_SELECTOR};
      p1AdvView[pmrv_pkg::AD_PAUSE] = state_ff.p1Pause;
      p1AdvView[pmrv_pkg::AD_ABIL_LSB +: 4] = state_ff.p1Adv;

      // Upper bits stay zero: no next page, ack or remote fault
      p1LpView = {11'h000, pmrv_pkg::AD_SELECTOR};
      p1LpView[pmrv_pkg::AD_PAUSE] = state_ff.p1LpPause;
      p1LpView[pmrv_pkg::AD_ABIL_LSB +: 4] = state_ff.p1LpAbil;

      p2CtrlView = 16'h0000;
      p2CtrlView[pmrv_pkg::BC_FAR_LOOP]   = state_ff.p2FarLoop;
      p2CtrlView[pmrv_pkg::BC_FORCE100]   = state_ff.p2Force100;
      p2CtrlView[pmrv_pkg::BC_AN_ENABLE]  = state_ff.p2AnEnable;
      p2CtrlView[pmrv_pkg::BC_POWER_DOWN] = state_ff.p2PowerDown;

      // Second view of the very same flops
      portCtrlView = 16'h0000;
      portCtrlView[pmrv_pkg::PC_DIS_LED]    = state_ff.p1DisLed;
      portCtrlView[pmrv_pkg::PC_DIS_TX]     = state_ff.p1DisTx;
      portCtrlView[pmrv_pkg::PC_RESTART_AN] = state_ff.p1RestartAn;
      portCtrlView[pmrv_pkg::PC_DIS_FEF]    = state_ff.p1DisFef;
      portCtrlView[pmrv_pkg::PC_POWER_DOWN] = state_ff.p1PowerDown;
      portCtrlView[pmrv_pkg::PC_DIS_XOVER]  = state_ff.p1DisXover;
      portCtrlView[pmrv_pkg::PC_FORCE_XOV]  = state_ff.p1ForceXov;
      portCtrlView[pmrv_pkg::PC_FAR_LOOP]   = state_ff.p1FarLoop;
      portCtrlView[pmrv_pkg::PC_AN_ENABLE]  = state_ff.p1AnEnable;
      portCtrlView[pmrv_pkg::PC_FORCE100]   = state_ff.p1Force100;
      portCtrlView[pmrv_pkg::PC_FULL_DUP]   = state_ff.p1FullDup;
      portCtrlView[pmrv_pkg::PC_PAUSE]      = state_ff.p1Pause;
      portCtrlView[3:0]                     = state_ff.p1Adv;

      portStatView = 16'h0000;
      portStatView[pmrv_pkg::PS_XOVER_STY] = state_ff.p1XoverSty;
      portStatView[pmrv_pkg::PS_FAR_FAULT] = state_ff.p1FarFault;
      portStatView[pmrv_pkg::PS_LINK_UP]   = state_ff.p1Link;
      portStatView[pmrv_pkg::PS_LP_PAUSE]  = state_ff.p1LpPause;
      portStatView[3:0]                    = state_ff.p1LpAbil;
   end

   // ----------------------------------------------------------------
   // Address decode
   // ----------------------------------------------------------------
   always_comb begin
      hit   = 1'b1;
      rdMux = 16'h0000;
      case (wordIdx)
         pmrv_pkg::IDX_P1_BASIC_CONTROL: rdMux = p1CtrlView;
         pmrv_pkg::IDX_P1_BASIC_STATUS:  rdMux = p1StatView;
         pmrv_pkg::IDX_P1_IDENT_LOW:     rdMux = pmrv_pkg::PHY_IDENT_LOW_VAL;
         pmrv_pkg::IDX_P1_IDENT_HIGH:    rdMux = pmrv_pkg::PHY_IDENT_HIGH_VAL;
         pmrv_pkg::IDX_P1_ADVERTISE:     rdMux = p1AdvView;
         pmrv_pkg::IDX_P1_PARTNER:       rdMux = p1LpView;
         pmrv_pkg::IDX_P2_BANK_BASE + pmrv_pkg::IDX_P2_BASIC_CONTROL: rdMux = p2CtrlView;
         pmrv_pkg::IDX_P1_PORT_CONTROL:  rdMux = portCtrlView;
         pmrv_pkg::IDX_P1_PORT_STATUS:   rdMux = portStatView;
         default:                        hit   = 1'b0;
      endcase
   end

   // Write lands on the edge where pready is seen high
   assign doWrite = psel & penable & pwrite & state_ff.ready;

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      nxt_state = state_ff;

      // One wait state keeps read data a flop output
      nxt_state.ready  = psel & penable & ~state_ff.ready;
      nxt_state.slverr = psel & penable & ~state_ff.ready & ~hit;
      if (psel & penable & ~state_ff.ready) begin
         nxt_state.rdata = pwrite ? 32'h0000_0000 : {16'h0000, rdMux};
      end

      // Status sampling; fault masked while detection is off
      nxt_state.p1Link     = p1LinkUpIn;
      nxt_state.p1FarFault = p1FarFaultRawIn & ~state_ff.p1DisFef;
      nxt_state.p1LpPause  = p1PartnerPauseIn;
      nxt_state.p1LpAbil   = p1PartnerAbilIn;

      if (doWrite) begin
         case (wordIdx)
            pmrv_pkg::IDX_P1_BASIC_CONTROL: begin
               nxt_state.p1FarLoop   = pwdata[pmrv_pkg::BC_FAR_LOOP];
               nxt_state.p1Force100  = pwdata[pmrv_pkg::BC_FORCE100];
               nxt_state.p1AnEnable  = pwdata[pmrv_pkg::BC_AN_ENABLE];
               nxt_state.p1PowerDown = pwdata[pmrv_pkg::BC_POWER_DOWN];
               nxt_state.p1RestartAn = pwdata[pmrv_pkg::BC_RESTART_AN];
               nxt_state.p1FullDup   = pwdata[pmrv_pkg::BC_FULL_DUP];
               nxt_state.p1XoverSty  = pwdata[pmrv_pkg::BC_XOVER_STY];
               nxt_state.p1ForceXov  = pwdata[pmrv_pkg::BC_FORCE_XOV];
               nxt_state.p1DisXover  = pwdata[pmrv_pkg::BC_DIS_XOVER];
               nxt_state.p1DisFef    = pwdata[pmrv_pkg::BC_DIS_FEF];
               nxt_state.p1DisTx     = pwdata[pmrv_pkg::BC_DIS_TX];
               nxt_state.p1DisLed    = pwdata[pmrv_pkg::BC_DIS_LED];
            end
            pmrv_pkg::IDX_P1_ADVERTISE: begin
               nxt_state.p1Pause = pwdata[pmrv_pkg::AD_PAUSE];
               nxt_state.p1Adv   = pwdata[pmrv_pkg::AD_ABIL_LSB +: 4];
            end
            pmrv_pkg::IDX_P2_BANK_BASE + pmrv_pkg::IDX_P2_BASIC_CONTROL: begin
               nxt_state.p2FarLoop   = pwdata[pmrv_pkg::BC_FAR_LOOP];
               nxt_state.p2Force100  = pwdata[pmrv_pkg::BC_FORCE100];
               nxt_state.p2AnEnable  = pwdata[pmrv_pkg::BC_AN_ENABLE];
               nxt_state.p2PowerDown = pwdata[pmrv_pkg::BC_POWER_DOWN];
            end
            pmrv_pkg::IDX_P1_PORT_CONTROL: begin
               nxt_state.p1DisLed    = pwdata[pmrv_pkg::PC_DIS_LED];
               nxt_state.p1DisTx     = pwdata[pmrv_pkg::PC_DIS_TX];
               nxt_state.p1RestartAn = pwdata[pmrv_pkg::PC_RESTART_AN];
               nxt_state.p1DisFef    = pwdata[pmrv_pkg::PC_DIS_FEF];
               nxt_state.p1PowerDown = pwdata[pmrv_pkg::PC_POWER_DOWN];
               nxt_state.p1DisXover  = pwdata[pmrv_pkg::PC_DIS_XOVER];
               nxt_state.p1ForceXov  = pwdata[pmrv_pkg::PC_FORCE_XOV];
               nxt_state.p1FarLoop   = pwdata[pmrv_pkg::PC_FAR_LOOP];
               nxt_state.p1AnEnable  = pwdata[pmrv_pkg::PC_AN_ENABLE];
               nxt_state.p1Force100  = pwdata[pmrv_pkg::PC_FORCE100];
               nxt_state.p1FullDup   = pwdata[pmrv_pkg::PC_FULL_DUP];
               nxt_state.p1Pause     = pwdata[pmrv_pkg::PC_PAUSE];
               nxt_state.p1Adv       = pwdata[3:0];
            end
            pmrv_pkg::IDX_P1_PORT_STATUS: begin
               nxt_state.p1XoverSty = pwdata[pmrv_pkg::PS_XOVER_STY];
            end
            default: begin
               // Read-only and unmapped words ignore writes
            end
         endcase
      end

      // Enable kept as its own flop so the output needs no inverter
      nxt_state.p1FefEn = ~nxt_state.p1DisFef;
   end

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (rst) begin
         state_ff            <= '0;
         state_ff.p1AnEnable <= pmrv_pkg::RST_AN_ENABLE;
         state_ff.p1XoverSty <= pmrv_pkg::RST_XOVER_STY;
         state_ff.p1FefEn    <= 1'b1;
         state_ff.p1Pause    <= pmrv_pkg::RST_PAUSE;
         state_ff.p1Adv      <= pmrv_pkg::RST_ADV_ABIL;
         state_ff.p2AnEnable <= pmrv_pkg::RST_AN_ENABLE;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // ----------------------------------------------------------------
   // Outputs, all straight from flops
   // ----------------------------------------------------------------
   assign prdata          = state_ff.rdata;
   assign pready          = state_ff.ready;
   assign pslverr         = state_ff.slverr;
   assign p1FarLoop       = state_ff.p1FarLoop;
   // Port 1 has no negotiation, so the forced bits always rule
   assign p1Speed100      = state_ff.p1Force100;
   assign p1FullDuplex    = state_ff.p1FullDup;
   assign p1XoverStyle    = state_ff.p1XoverSty;
   assign p1AutoXoverOff  = state_ff.p1DisXover;
   assign p1ForceXover    = state_ff.p1ForceXov;
   assign p1FarFaultDetEn = state_ff.p1FefEn;
   assign p1PowerDown     = state_ff.p1PowerDown;
   assign p1TxDisable     = state_ff.p1DisTx;
   assign p1LedDisable    = state_ff.p1DisLed;
   assign p1AdvPause      = state_ff.p1Pause;
   assign p1AdvAbil       = state_ff.p1Adv;
   assign p2FarLoop       = state_ff.p2FarLoop;
   assign p2Speed100      = state_ff.p2Force100;
   assign p2AnEnable      = state_ff.p2AnEnable;
   assign p2PowerDown     = state_ff.p2PowerDown;

endmodule : pmrv_phy_mii_register_view

`default_nettype wire

/* hdl/pmrv_pkg.sv */
/*
 * Constants shared by the port 1 / port 2 management register view:
 * register indices (with their byte-address rule), field positions and reset values.
 * Assumes a 32-bit APB with 16-bit registers in the low half of each word.
 */
package pmrv_pkg;
   // ----------------------------------------------------------------
   // Register indices (byte address = 4 * index)
   // ----------------------------------------------------------------
   localparam logic [9:0] IDX_P1_BASIC_CONTROL   = 10'h000;
   localparam logic [9:0] IDX_P1_BASIC_STATUS    = 10'h002;
   localparam logic [9:0] IDX_P1_IDENT_LOW       = 10'h004;
   localparam logic [9:0] IDX_P1_IDENT_HIGH      = 10'h006;
   localparam logic [9:0] IDX_P1_ADVERTISE       = 10'h008;
   localparam logic [9:0] IDX_P1_PARTNER         = 10'h00A;
   localparam logic [9:0] IDX_P2_BASIC_CONTROL   = 10'h000;
   // Port 2 bank sits above port 1 bank
   localparam logic [9:0] IDX_P2_BANK_BASE       = 10'h020;
   // Per-port control and status views sharing the same storage
   localparam logic [9:0] IDX_P1_PORT_CONTROL    = 10'h031;
   localparam logic [9:0] IDX_P1_PORT_STATUS     = 10'h032;

   // ----------------------------------------------------------------
   // Identifier values (arbitrary, neutral)
   // ----------------------------------------------------------------
   localparam logic [15:0] PHY_IDENT_LOW_VAL     = 16'hA5A5; // Arbitrary value
   localparam logic [15:0] PHY_IDENT_HIGH_VAL    = 16'h0101; // Arbitrary value

   // ----------------------------------------------------------------
   // Basic control field positions
   // ----------------------------------------------------------------
   localparam int BC_FAR_LOOP   = 14;
   localparam int BC_FORCE100   = 13;
   localparam int BC_AN_ENABLE  = 12;
   localparam int BC_POWER_DOWN = 11;
   localparam int BC_RESTART_AN = 9;
   localparam int BC_FULL_DUP   = 8;
   localparam int BC_XOVER_STY  = 5;
   localparam int BC_FORCE_XOV  = 4;
   localparam int BC_DIS_XOVER  = 3;
   localparam int BC_DIS_FEF    = 2;
   localparam int BC_DIS_TX     = 1;
   localparam int BC_DIS_LED    = 0;

   // ----------------------------------------------------------------
   // Status, advertisement and partner field positions
   // ----------------------------------------------------------------
   localparam int BS_FAR_FAULT  = 4;
   localparam int BS_LINK_UP    = 2;
   localparam logic [15:0] BS_FIXED_BITS  = 16'h7808; // Caps 14..11, bit 3
   localparam int AD_PAUSE      = 10;
   localparam int AD_ABIL_LSB   = 5;
   localparam logic [4:0] AD_SELECTOR     = 5'h01;

   // ----------------------------------------------------------------
   // Per-port control / status view field positions
   // ----------------------------------------------------------------
   localparam int PC_DIS_LED    = 15;
   localparam int PC_DIS_TX     = 14;
   localparam int PC_RESTART_AN = 13;
   localparam int PC_DIS_FEF    = 12;
   localparam int PC_POWER_DOWN = 11;
   localparam int PC_DIS_XOVER  = 10;
   localparam int PC_FORCE_XOV  = 9;
   localparam int PC_FAR_LOOP   = 8;
   localparam int PC_AN_ENABLE  = 7;
   localparam int PC_FORCE100   = 6;
   localparam int PC_FULL_DUP   = 5;
   localparam int PC_PAUSE      = 4;
   localparam int PS_XOVER_STY  = 15;
   localparam int PS_FAR_FAULT  = 8;
   localparam int PS_LINK_UP    = 5;
   localparam int PS_LP_PAUSE   = 4;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic       RST_AN_ENABLE = 1'b1;
   localparam logic       RST_XOVER_STY = 1'b1;
   localparam logic       RST_PAUSE     = 1'b1;
   localparam logic [3:0] RST_ADV_ABIL  = 4'hF;
endpackage : pmrv_pkg

/* bench/pmrv_view_props.sv */
/*
 * Checker for the port management register view, bound to its top.
 * Assumes one clock, synchronous active-high reset, APB with one wait.
 */
`timescale 1ns/1ps
`default_nettype none
module pmrv_view_props (
   input wire logic        clock,
   input wire logic        rst,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        p1LinkUpIn,
   input wire logic        p1FarLoop,
   input wire logic        p1Speed100,
   input wire logic        p1FullDuplex,
   input wire logic        p1XoverStyle,
   input wire logic        p1AutoXoverOff,
   input wire logic        p1ForceXover,
   input wire logic        p1FarFaultDetEn,
   input wire logic        p1AdvPause,
   input wire logic [3:0]  p1AdvAbil,
   input wire logic        p2FarLoop,
   input wire logic        p2AnEnable
);
   // ----------------------------------------------------------------
   // Properties
   // ----------------------------------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);
   wire logic wrDone = psel && penable && pready && pwrite;
   wire logic rdDone = psel && penable && pready && !pwrite;
   a_ready_one_wait: assert property ($rose(penable) && psel |-> !pready ##1 pready)
      else $error("pready not after one wait");
   a_ready_single: assert property (pready |=> !pready)
      else $error("pready held too long");
   a_unmapped_err: assert property (pready && paddr == 12'h004 |-> pslverr && prdata == 32'h0)
      else $error("unmapped access not refused");
   a_ctrl_loop_speed: assert property (wrDone && paddr == 12'h000 |=>
      p1FarLoop == $past(pwdata[14]) && p1Speed100 == $past(pwdata[13])) else $error("loop/speed");
   a_ctrl_dup_xover: assert property (wrDone && paddr == 12'h000 |=>
      {p1FullDuplex, p1ForceXover, p1AutoXoverOff} == {$past(pwdata[8]), $past(pwdata[4:3])})
      else $error("duplex/crossover");
   a_ctrl_fef_style: assert property (wrDone && paddr == 12'h000 |=>
      p1FarFaultDetEn == !$past(pwdata[2]) && p1XoverStyle == $past(pwdata[5])) else $error("fef");
   a_p2_ctrl: assert property (wrDone && paddr == 12'h080 |=>
      p2FarLoop == $past(pwdata[14]) && p2AnEnable == $past(pwdata[12])) else $error("port 2");
   a_adv_write: assert property (wrDone && paddr == 12'h020 |=>
      {p1AdvPause, p1AdvAbil} == {$past(pwdata[10]), $past(pwdata[8:5])}) else $error("adv");
   a_status_fixed: assert property (rdDone && paddr == 12'h008 |->
      prdata[15:11] == 5'h0F && prdata[1:0] == 2'h0 && prdata[6] == 1'b0) else $error("caps");
   a_link_status: assert property (rdDone && paddr == 12'h008 |->
      prdata[2] == $past(p1LinkUpIn, 2)) else $error("link bit");
   a_partner_fixed: assert property (rdDone && paddr == 12'h028 |->
      prdata[15:11] == 5'h00 && prdata[4:0] == 5'h01) else $error("partner fixed bits");
   c_ctrl_write: cover property (wrDone && paddr == 12'h000);
   c_unmapped: cover property (pready && pslverr);
   c_link_read: cover property (rdDone && paddr == 12'h008 && prdata[2]);
endmodule : pmrv_view_props
bind pmrv_phy_mii_register_view pmrv_view_props i_props (
   .clock, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
   .p1LinkUpIn, .p1FarLoop, .p1Speed100, .p1FullDuplex, .p1XoverStyle, .p1AutoXoverOff,
   .p1ForceXover, .p1FarFaultDetEn, .p1AdvPause, .p1AdvAbil, .p2FarLoop, .p2AnEnable);
`default_nettype wire

/* bench/pmrv_phy_model.sv */
/*
 * Behavioural model of the port 1 line side: link, fault, partner.
 * Assumes the bench steers it by request levels on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none
module pmrv_phy_model (
   input  wire logic       clock,
   input  wire logic       linkReq,
   input  wire logic       faultReq,
   input  wire logic       pauseReq,
   input  wire logic [3:0] abilReq,
   input  wire logic       powerDown,
   output logic            linkUp,
   output logic            farFaultRaw,
   output logic            partnerPause,
   output logic      [3:0] partnerAbil
);
   // ----------------------------------------------------------------
   // Line state
   // ----------------------------------------------------------------
   always_ff @(posedge clock) begin
      // A powered-down port cannot hold a link
      linkUp       <= linkReq && !powerDown;
      farFaultRaw  <= faultReq;
      partnerPause <= pauseReq;
      partnerAbil  <= abilReq;
   end
endmodule : pmrv_phy_model
`default_nettype wire

/* bench/pmrv_phy_mii_register_view_tb_top.sv */
/*
 * Self-checking bench: APB register accesses with expected values.
 * Assumes the design answers each access after one wait state.
 */
`timescale 1ns/1ps
`default_nettype none
module pmrv_phy_mii_register_view_tb_top;
   logic clock = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata;
   logic pready, pslverr, lkReq = 1'b0, ffReq = 1'b0, psReq = 1'b0;
   logic [3:0] abReq = 4'h0, p1AdvAbil, p1PartnerAbilIn;
   logic p1LinkUpIn, p1FarFaultRawIn, p1PartnerPauseIn, p1FarLoop, p1Speed100;
   logic p1FullDuplex, p1XoverStyle, p1AutoXoverOff, p1ForceXover, p1FarFaultDetEn;
   logic p1PowerDown, p1TxDisable, p1LedDisable, p1AdvPause;
   logic p2FarLoop, p2Speed100, p2AnEnable, p2PowerDown;
   int bad_count = 0, n_checks = 0;
   pmrv_phy_mii_register_view i_dut (
      .clock, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .p1LinkUpIn, .p1FarFaultRawIn, .p1PartnerPauseIn, .p1PartnerAbilIn, .p1FarLoop,
      .p1Speed100, .p1FullDuplex, .p1XoverStyle, .p1AutoXoverOff, .p1ForceXover,
      .p1FarFaultDetEn, .p1PowerDown, .p1TxDisable, .p1LedDisable, .p1AdvPause, .p1AdvAbil,
      .p2FarLoop, .p2Speed100, .p2AnEnable, .p2PowerDown);
   pmrv_phy_model i_phy (.clock(clock), .linkReq(lkReq), .faultReq(ffReq), .pauseReq(psReq),
      .abilReq(abReq), .powerDown(p1PowerDown), .linkUp(p1LinkUpIn),
      .farFaultRaw(p1FarFaultRawIn), .partnerPause(p1PartnerPauseIn),
      .partnerAbil(p1PartnerAbilIn));
   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   always #12.5 clock = ~clock;
   task automatic final_report();
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : final_report
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
         bad_count++;
      end
   endtask : chk
   // Request held from setup until pready is seen high at an edge
   task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d,
                      input logic [31:0] exp, input logic eErr);
      logic [31:0] rd;
      logic        er;
      int          n;
      @(posedge clock);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clock);
         n++;
      end while (pready !== 1'b1 && n < 20);
      chk("pready", {31'h0, pready}, 32'h1);
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      chk($sformatf("data at %h", a), rd, exp);
      chk("pslverr", {31'h0, er}, {31'h0, eErr});
   endtask : acc
   task automatic outs(input logic [14:0] e, input logic [3:0] e2);
      @(posedge clock);
      chk("p1 outs", {17'h0, p1FarLoop, p1Speed100, p1FullDuplex, p1XoverStyle,
         p1AutoXoverOff, p1ForceXover, p1FarFaultDetEn, p1PowerDown, p1TxDisable,
         p1LedDisable, p1AdvPause, p1AdvAbil}, {17'h0, e});
      chk("p2 outs", {28'h0, p2FarLoop, p2Speed100, p2AnEnable, p2PowerDown}, {28'h0, e2});
   endtask : outs
   initial begin
      repeat (3000) @(posedge clock);
      bad_count++;
      final_report();
   end
   // ----------------------------------------------------------------
   // Tests
   // ----------------------------------------------------------------
   initial begin
      repeat (10) @(posedge clock);
      rst <= 1'b0;
      outs(15'h091F, 4'h2);
      acc(1'b0, 12'h000, 32'h0, 32'h1020, 1'b0);
      acc(1'b0, 12'h008, 32'h0, 32'h7808, 1'b0);
      acc(1'b0, 12'h010, 32'h0, 32'h0000A5A5, 1'b0);
      acc(1'b0, 12'h018, 32'h0, 32'h00000101, 1'b0);
      acc(1'b0, 12'h020, 32'h0, 32'h05E1, 1'b0);
      acc(1'b0, 12'h028, 32'h0, 32'h0001, 1'b0);
      acc(1'b1, 12'h000, 32'hFFFF, 32'h0, 1'b0);
      outs(15'h7EFF, 4'h2);
      acc(1'b0, 12'h000, 32'h0, 32'h7B3F, 1'b0);
      acc(1'b1, 12'h000, 32'h0, 32'h0, 1'b0);
      outs(15'h011F, 4'h2);
      acc(1'b0, 12'h0C4, 32'h0, 32'h001F, 1'b0);
      acc(1'b1, 12'h0C4, 32'h0140, 32'h0, 1'b0);
      acc(1'b0, 12'h000, 32'h0, 32'h6000, 1'b0);
      acc(1'b0, 12'h020, 32'h0, 32'h0001, 1'b0);
      outs(15'h6100, 4'h2);
      acc(1'b1, 12'h020, 32'hFFFF, 32'h0, 1'b0);
      acc(1'b0, 12'h020, 32'h0, 32'h05E1, 1'b0);
      lkReq <= 1'b1;
      ffReq <= 1'b1;
      psReq <= 1'b1;
      abReq <= 4'hA;
      repeat (4) @(posedge clock);
      acc(1'b0, 12'h008, 32'h0, 32'h781C, 1'b0);
      acc(1'b0, 12'h028, 32'h0, 32'h0541, 1'b0);
      acc(1'b0, 12'h0C8, 32'h0, 32'h013A, 1'b0);
      acc(1'b1, 12'h000, 32'h0004, 32'h0, 1'b0);
      acc(1'b0, 12'h008, 32'h0, 32'h780C, 1'b0);
      acc(1'b1, 12'h000, 32'h0800, 32'h0, 1'b0);
      repeat (3) @(posedge clock);
      acc(1'b0, 12'h008, 32'h0, 32'h7818, 1'b0);
      acc(1'b1, 12'h010, 32'hFFFF, 32'h0, 1'b0);
      acc(1'b0, 12'h010, 32'h0, 32'h0000A5A5, 1'b0);
      acc(1'b0, 12'h004, 32'h0, 32'h0, 1'b1);
      acc(1'b1, 12'h0FC, 32'hFFFF, 32'h0, 1'b1);
      acc(1'b1, 12'h080, 32'hFFFF, 32'h0, 1'b0);
      acc(1'b0, 12'h080, 32'h0, 32'h7800, 1'b0);
      outs(15'h019F, 4'hF);
      acc(1'b1, 12'h080, 32'h0, 32'h0, 1'b0);
      outs(15'h019F, 4'h0);
      final_report();
   end
endmodule : pmrv_phy_mii_register_view_tb_top
`default_nettype wire
